/* verilog/ebr_pkg.sv */
// Shared constants and types of the external bus ready and arbitration block.
package ebr_pkg;

    // System clocks per half period of the bus reference clock.
    localparam int REF_HALF = 2;
    // System clocks per reference clock period, one bus phase unit.
    localparam int TCS_CYC  = 2 * REF_HALF;

    // Register offsets on the plain register port.
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_TIM0 = 4'h4;
    localparam logic [3:0] ADR_TIM1 = 4'h8;
    localparam logic [3:0] ADR_STAT = 4'hC;

    // Control register field positions.
    localparam int CTRL_ASYNC = 0;
    localparam int CTRL_POLHI = 1;
    localparam int CTRL_ARB   = 2;
    // Control reset: synchronous ready, active high, arbitration off.
    localparam logic [2:0] CTRL_RST = 3'h2;

    // Address bit that selects one of the two window timing sets.
    localparam int WIN_BIT = 23;

    // Per window phase lengths, in reference clock periods.
    typedef struct packed {
        logic       rdy_en; // Access phase may be stretched by ready.
        logic [1:0] f;      // Hold phase, 0 to 3.
        logic [4:0] e;      // Access phase minus one, 1 to 32.
        logic       d;      // Write data setup phase, 0 to 1.
        logic [1:0] c;      // Command delay phase, 0 to 3.
        logic       ab;     // Address phase minus one, 1 to 2.
    } ebr_timing_t;

    localparam logic [11:0] TIM_RST = 12'h000;

    // One internal bus request.
    typedef struct packed {
        logic        write;
        logic [23:0] addr;
        logic [15:0] wdata;
    } ebr_req_t;

    // Bus control outputs, all driven from flip-flops.
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic ale;
        logic cs_n;
        logic high_byte_enable_n;
    } ebr_ctl_t;

    // Controller states, one-hot.
    typedef enum logic [8:0] {
        ST_IDLE  = 9'h001,
        ST_ADDR  = 9'h002,
        ST_CMD   = 9'h004,
        ST_DSET  = 9'h008,
        ST_ACC   = 9'h010,
        ST_RDYW  = 9'h020,
        ST_HOLDP = 9'h040,
        ST_REL   = 9'h080,
        ST_REGN  = 9'h100
    } ebr_state_t;

endpackage : ebr_pkg

/* verilog/ebr_sync2.sv */
// Two flip-flop synchroniser for pin inputs.
module ebr_sync2 #(
    parameter int WIDTH = 1 // Number of bits carried across.
) (
    input  wire logic             clk_sys_in, // System clock.
    input  wire logic             rst_in,     // Synchronous reset, active high.
    input  wire logic [WIDTH-1:0] d_in,       // Asynchronous pin levels.
    input  wire logic [WIDTH-1:0] rst_val_in, // Idle level, a constant at the instance.
    output logic      [WIDTH-1:0] q_out       // Synchronised levels.
);

    // First stage, read by the second stage only.
    logic [WIDTH-1:0] meta_reg;

    // Both stages take the idle level in reset so no false edge appears.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            meta_reg <= rst_val_in;
            q_out    <= rst_val_in;
        end
        else
        begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end

endmodule : ebr_sync2

/* verilog/ebr_ctrl.sv */
// External bus controller: phase sequencer, ready handshake and bus arbitration.
//
// Local design decisions: the address-and-strobe port and the address map.

module ebr_ctrl (
    input  wire logic              clk_sys_in,              // System clock, 250 MHz.
    input  wire logic              rst_in,                  // Synchronous reset, active high.
    input  wire logic [3:0]        reg_addr_in,             // Register byte address.
    input  wire logic [31:0]       reg_wdata_in,            // Register write data.
    input  wire logic              reg_wr_in,               // Register write strobe.
    input  wire logic              reg_rd_in,               // Register read strobe.
    output logic      [31:0]       reg_rdata_out,           // Read data, one cycle later.
    input  wire logic              req_valid_in,            // Internal bus request pending.
    input  wire ebr_pkg::ebr_req_t req_in,                  // Request contents.
    output logic                   req_accept_out,          // Request taken, one pulse.
    output logic                   rsp_valid_out,           // Access finished, one pulse.
    output logic      [15:0]       rsp_rdata_out,           // Captured read data.
    input  wire logic              ready_in,                // Ready pin.
    input  wire logic              hold_n_in,               // Hold request pin, active low.
    input  wire logic [15:0]       data_in,                 // Data pins, input side.
    output logic                   bus_reference_clock_out, // Reference clock out.
    output logic      [23:0]       addr_out,                // Address pins.
    output logic      [15:0]       data_out,                // Data pins, output side.
    output logic                   data_oe_n_out,           // Data drive, low drives.
    output ebr_pkg::ebr_ctl_t      ctl_out,                 // Control pins.
    output logic                   bus_oe_n_out,            // Control and address drive, low drives.
    output logic                   bus_grant_ack_out,       // Bus handed to other master.
    output logic                   bus_regain_request_out   // Device wants bus back.
);

    // Register state.
    logic [2:0]           ctrl_reg;            // Async, polarity, arbitration enable.
    ebr_pkg::ebr_timing_t tim_reg [2];         // Two window timing sets.
    ebr_pkg::ebr_timing_t cur_reg;             // Timing latched for running cycle.
    ebr_pkg::ebr_req_t    req_reg;             // Request latched for running cycle.
    // Sequencer state.
    ebr_pkg::ebr_state_t  st_reg;              // Current state.
    ebr_pkg::ebr_state_t  st_next;             // Next state.
    logic [4:0]           cnt_reg;             // Phase countdown.
    logic [4:0]           cnt_next;            // Next countdown.
    logic [1:0]           div_reg;             // Reference clock divider.
    logic                 tick;                // Last system clock of a period.
    // Pin sampling.
    logic [17:0]          pin_s;               // Synchronised ready, hold, data.
    logic                 rdy_s;               // Ready after the pin synchroniser.
    logic                 hold_act;            // Hold requested.
    logic                 rdy_a_reg;           // Extra asynchronous stage.
    logic                 rdy_act;             // Ready seen active at sample point.
    // Named control bits.
    logic                 async_mode;
    logic                 pol_hi;
    logic                 arb_en;
    assign async_mode = ctrl_reg[ebr_pkg::CTRL_ASYNC];
    assign pol_hi     = ctrl_reg[ebr_pkg::CTRL_POLHI];
    assign arb_en     = ctrl_reg[ebr_pkg::CTRL_ARB];
    // True while the read or write command is low.
    function automatic logic is_cmd(input ebr_pkg::ebr_state_t s);
        is_cmd = (s == ebr_pkg::ST_ACC) || (s == ebr_pkg::ST_RDYW);
    endfunction : is_cmd
    // True while a bus cycle owns the bus.
    function automatic logic in_cycle(input ebr_pkg::ebr_state_t s);
        in_cycle = (s == ebr_pkg::ST_ADDR) || (s == ebr_pkg::ST_CMD) || (s == ebr_pkg::ST_DSET)
                   || is_cmd(s) || (s == ebr_pkg::ST_HOLDP);
    endfunction : in_cycle
    // All pins pass two flops; ready then serves the synchronous mode directly.
    ebr_sync2 #(
        .WIDTH (18)
    ) u_pins (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .d_in       ({ready_in, hold_n_in, data_in}),
        .rst_val_in (18'h1_0000),
        .q_out      (pin_s)
    );
    assign rdy_s    = pin_s[17];
    assign hold_act = !pin_s[16];
    // The divider sets the phase unit and drives the reference clock out.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            div_reg                 <= 2'h0;
            bus_reference_clock_out <= 1'b0;
        end
        else
        begin
            div_reg                 <= tick ? 2'h0 : div_reg + 2'h1;
            bus_reference_clock_out <= (div_reg >= 2'(ebr_pkg::REF_HALF - 1)) && !tick;
        end
    end
    assign tick = (div_reg == 2'(ebr_pkg::TCS_CYC - 1));
    // Asynchronous mode adds one period-wide stage, costing a waitstate.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            rdy_a_reg <= 1'b0;
        else if (tick)
            rdy_a_reg <= rdy_s;
    end
    // The mode picks the sampling instant; polarity decides which level counts.
    assign rdy_act = (async_mode ? rdy_a_reg : rdy_s) == pol_hi;
    // Register writes steer the sequencer.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            ctrl_reg   <= ebr_pkg::CTRL_RST;
            tim_reg[0] <= ebr_pkg::TIM_RST;
            tim_reg[1] <= ebr_pkg::TIM_RST;
        end
        else if (reg_wr_in)
        begin
            case (reg_addr_in)
                ebr_pkg::ADR_CTRL: ctrl_reg   <= reg_wdata_in[2:0];
                ebr_pkg::ADR_TIM0: tim_reg[0] <= reg_wdata_in[11:0];
                ebr_pkg::ADR_TIM1: tim_reg[1] <= reg_wdata_in[11:0];
                default: ;
            endcase
        end
    end
    // Reads answer the cycle after the strobe; anything else reads zero.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || !reg_rd_in)
            reg_rdata_out <= 32'h0000_0000;
        else
        begin
            case (reg_addr_in)
                ebr_pkg::ADR_CTRL: reg_rdata_out <= {29'h0000_0000, ctrl_reg};
                ebr_pkg::ADR_TIM0: reg_rdata_out <= {20'h0_0000, tim_reg[0]};
                ebr_pkg::ADR_TIM1: reg_rdata_out <= {20'h0_0000, tim_reg[1]};
                ebr_pkg::ADR_STAT: reg_rdata_out <= {20'h0_0000, bus_grant_ack_out, hold_act, rdy_act, st_reg};
                default:           reg_rdata_out <= 32'h0000_0000;
            endcase
        end
    end
    // Phase sequencer; every step lands on a reference clock boundary.
    always_comb
    begin
        st_next  = st_reg;
        cnt_next = cnt_reg;
        if (tick)
        begin
            case (st_reg)
                ebr_pkg::ST_IDLE:
                begin
                    // Hold is looked at only between cycles.
                    if (hold_act && arb_en)
                        st_next = ebr_pkg::ST_REL;
                    else if (req_valid_in)
                    begin
                        st_next  = ebr_pkg::ST_ADDR;
                        cnt_next = {4'h0, tim_reg[req_in.addr[ebr_pkg::WIN_BIT]].ab};
                    end
                end
                ebr_pkg::ST_ADDR, ebr_pkg::ST_CMD, ebr_pkg::ST_DSET:
                begin
                    if (cnt_reg != 5'h00)
                        cnt_next = cnt_reg - 5'h01;
                    else if ((st_reg == ebr_pkg::ST_ADDR) && (cur_reg.c != 2'h0))
                    begin
                        st_next  = ebr_pkg::ST_CMD;
                        cnt_next = {3'h0, cur_reg.c - 2'h1};
                    end
                    else if ((st_reg != ebr_pkg::ST_DSET) && cur_reg.d)
                    begin
                        st_next  = ebr_pkg::ST_DSET;
                        cnt_next = 5'h00;
                    end
                    else
                    begin
                        // Programmed lengths place the first ready sample.
                        st_next  = ebr_pkg::ST_ACC;
                        cnt_next = cur_reg.e;
                    end
                end
                ebr_pkg::ST_ACC:
                begin
                    if (cnt_reg != 5'h00)
                        cnt_next = cnt_reg - 5'h01;
                    else if (cur_reg.rdy_en && (async_mode || !rdy_act))
                        st_next = ebr_pkg::ST_RDYW;
                    else
                    begin
                        st_next  = (cur_reg.f != 2'h0) ? ebr_pkg::ST_HOLDP : ebr_pkg::ST_IDLE;
                        cnt_next = {3'h0, cur_reg.f - 2'h1};
                    end
                end
                ebr_pkg::ST_RDYW:
                begin
                    // Stay one more waitstate per inactive sample.
                    if (rdy_act)
                    begin
                        st_next  = (cur_reg.f != 2'h0) ? ebr_pkg::ST_HOLDP : ebr_pkg::ST_IDLE;
                        cnt_next = {3'h0, cur_reg.f - 2'h1};
                    end
                end
                ebr_pkg::ST_HOLDP:
                begin
                    if (cnt_reg != 5'h00)
                        cnt_next = cnt_reg - 5'h01;
                    else
                        st_next = ebr_pkg::ST_IDLE;
                end
                ebr_pkg::ST_REL:
                begin
                    // Only hold going high ends the release.
                    if (!hold_act)
                        st_next = ebr_pkg::ST_REGN;
                end
                ebr_pkg::ST_REGN:
                    st_next = ebr_pkg::ST_IDLE;
                default:
                    st_next = ebr_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            st_reg  <= ebr_pkg::ST_IDLE;
            cnt_reg <= 5'h00;
        end
        else
        begin
            st_reg  <= st_next;
            cnt_reg <= cnt_next;
        end
    end
    // Request capture; a request waits in place while the bus is away.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            req_reg        <= '0;
            cur_reg        <= ebr_pkg::TIM_RST;
            req_accept_out <= 1'b0;
        end
        else
        begin
            req_accept_out <= (st_reg == ebr_pkg::ST_IDLE) && (st_next == ebr_pkg::ST_ADDR);
            if ((st_reg == ebr_pkg::ST_IDLE) && (st_next == ebr_pkg::ST_ADDR))
            begin
                req_reg <= req_in;
                cur_reg <= tim_reg[req_in.addr[ebr_pkg::WIN_BIT]];
            end
        end
    end
    // Pin outputs follow the next state so each comes from a flop.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            ctl_out           <= '{rd_n: 1'b1, wr_n: 1'b1, ale: 1'b0, cs_n: 1'b1, high_byte_enable_n: 1'b1};
            addr_out          <= 24'h00_0000;
            data_out          <= 16'h0000;
            data_oe_n_out     <= 1'b1;
            bus_oe_n_out      <= 1'b0;
            bus_grant_ack_out <= 1'b0;
        end
        else
        begin
            ctl_out.ale                <= (st_next == ebr_pkg::ST_ADDR);
            ctl_out.cs_n               <= !in_cycle(st_next);
            ctl_out.rd_n               <= !(is_cmd(st_next) && !req_reg.write);
            ctl_out.wr_n               <= !(is_cmd(st_next) && req_reg.write);
            ctl_out.high_byte_enable_n <= !in_cycle(st_next);
            if ((st_reg == ebr_pkg::ST_IDLE) && (st_next == ebr_pkg::ST_ADDR))
            begin
                addr_out <= req_in.addr;
                data_out <= req_in.wdata;
            end
            data_oe_n_out     <= !(req_reg.write && in_cycle(st_next) && (st_next != ebr_pkg::ST_ADDR));
            // Controls were already driven inactive in idle; only then do they float.
            bus_oe_n_out      <= (st_next == ebr_pkg::ST_REL);
            bus_grant_ack_out <= (st_next == ebr_pkg::ST_REL);
        end
    end
    // The bus request shows a stalled request; it does not itself end the release.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            bus_regain_request_out <= 1'b0;
        else
            bus_regain_request_out <= (st_next == ebr_pkg::ST_REL) && req_valid_in;
    end
    // Read data are taken on the edge that raises the read strobe.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= 16'h0000;
        end
        else
        begin
            rsp_valid_out <= is_cmd(st_reg) && !is_cmd(st_next);
            if (is_cmd(st_reg) && !is_cmd(st_next) && !req_reg.write)
                rsp_rdata_out <= pin_s[15:0];
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    grant_after_idle_a: assert property ($rose(bus_grant_ack_out) |-> $past(st_reg, 2) == ebr_pkg::ST_IDLE)
        else $error("Bus granted in the middle of a cycle.");
    hold_release_a: assert property (tick && st_reg == ebr_pkg::ST_IDLE && hold_act && arb_en
                                     |=> ##1 bus_grant_ack_out && bus_oe_n_out && !ctl_out.ale)
        else $error("Enabled hold did not release the bus.");
    ready_ignore_a: assert property (tick && st_reg == ebr_pkg::ST_ACC && cnt_reg != 5'h00
                                     |=> st_reg == ebr_pkg::ST_ACC)
        else $error("Access phase cut short.");
    async_wait_a: assert property (tick && st_reg == ebr_pkg::ST_ACC && cnt_reg == 5'h00 && cur_reg.rdy_en
                                   && async_mode |=> st_reg == ebr_pkg::ST_RDYW)
        else $error("Asynchronous ready skipped its waitstate.");
    ready_wait_a: assert property (tick && st_reg == ebr_pkg::ST_RDYW && !rdy_act
                                   |=> st_reg == ebr_pkg::ST_RDYW [*4])
        else $error("Inactive ready did not add a waitstate.");
    ready_end_a: assert property (tick && st_reg == ebr_pkg::ST_RDYW && rdy_act
                                  |=> ctl_out.rd_n && ctl_out.wr_n ##0 $rose(rsp_valid_out))
        else $error("Active ready did not end the access.");
    read_capture_a: assert property ($rose(ctl_out.rd_n) && !req_reg.write
                                     |-> rsp_rdata_out == $past(pin_s[15:0]))
        else $error("Read data not taken with the strobe edge.");
    release_keep_a: assert property (st_reg == ebr_pkg::ST_REL && hold_act
                                     |=> st_reg == ebr_pkg::ST_REL && !req_accept_out)
        else $error("Bus regained while hold still active.");
    regain_drive_a: assert property (st_reg == ebr_pkg::ST_REGN |-> !bus_oe_n_out && ctl_out.rd_n
                                     && ctl_out.wr_n && ctl_out.cs_n && !ctl_out.ale)
        else $error("Controls not driven inactive on regain.");
    polarity_a: assert property (tick && st_reg == ebr_pkg::ST_RDYW && !async_mode && (rdy_s != pol_hi)
                                 |=> st_reg == ebr_pkg::ST_RDYW)
        else $error("Ready level taken with wrong polarity.");

    ready_stretch_c: cover property (st_reg == ebr_pkg::ST_RDYW ##1 st_reg == ebr_pkg::ST_HOLDP);
    release_regain_c: cover property (st_reg == ebr_pkg::ST_REL ##[1:200] st_reg == ebr_pkg::ST_REGN);
    stalled_req_c: cover property (bus_regain_request_out ##[1:200] req_accept_out);

endmodule : ebr_ctrl

/* dv/ebr_mem_model.sv */
// Behavioural external memory that answers reads and drives the ready pin.
module ebr_mem_model (
    input  wire logic              clk_sys_in, // System clock.
    input  wire logic              refclk_in,  // Bus reference clock.
    input  wire ebr_pkg::ebr_ctl_t ctl_in,     // Control pins.
    input  wire logic              pol_hi_in,  // Ready is active high.
    input  wire logic              async_in,   // Ready moves off the reference clock.
    input  wire logic [31:0]       delay_in,   // Command periods before ready.
    output logic                   ready_out,  // Ready pin.
    output logic      [15:0]       data_out    // Data pins.
);
    timeunit 1ns;
    timeprecision 100ps;
    int   n   = 0; // Reference periods seen with a command low.
    logic cmd;     // A command strobe is low.
    assign cmd = !(ctl_in.rd_n && ctl_in.wr_n);
    initial ready_out = 1'b0;
    initial data_out = 16'h0000;
    // Ready is asserted after the delay and dropped once the command has risen.
    // In asynchronous mode it moves 3 ns after the reference edge to stay off its phase.
    always @(posedge refclk_in)
    begin
        if (async_in)
            #3;
        n = cmd ? n + 1 : 0;
        ready_out = (cmd && n > delay_in) == pol_hi_in;
    end
    // Read data stand only while the read strobe is low; after that they toggle.
    always @(posedge clk_sys_in)
        data_out <= !ctl_in.rd_n ? 16'hA5C3 : ~data_out;
endmodule : ebr_mem_model

/* dv/testbench.sv */
// Self-checking bench for the external bus ready and arbitration block.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, req_valid_in = 0, hold_n_in = 1;
    logic [3:0]  reg_addr_in  = '0;
    logic [31:0] reg_wdata_in = '0, reg_rdata_out, rv;
    ebr_pkg::ebr_req_t req_in = '0;
    ebr_pkg::ebr_ctl_t ctl_out;
    logic req_accept_out, rsp_valid_out, ready_in, bus_reference_clock_out, data_oe_n_out, bus_oe_n_out;
    logic bus_grant_ack_out, bus_regain_request_out, pol_hi = 1, async_md = 0;
    logic [15:0] rsp_rdata_out, data_in, data_out;
    logic [23:0] addr_out;
    int   delay = 0, errors = 0, check_count = 0, lat, base;
    ebr_ctrl ebr_ctrl_i (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out, .req_valid_in, .req_in, .req_accept_out, .rsp_valid_out, .rsp_rdata_out, .ready_in,
        .hold_n_in, .data_in, .bus_reference_clock_out, .addr_out, .data_out, .data_oe_n_out, .ctl_out,
        .bus_oe_n_out, .bus_grant_ack_out, .bus_regain_request_out);
    ebr_mem_model ebr_mem_model_i (.clk_sys_in, .refclk_in(bus_reference_clock_out), .ctl_in(ctl_out),
        .pol_hi_in(pol_hi), .async_in(async_md), .delay_in(delay), .ready_out(ready_in), .data_out(data_in));
    // Free running system clock.
    initial
    begin
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    task automatic tally_and_finish();
        $display("Checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Bounded wait; running out of time ends the run as a failure.
    task automatic wait_for(ref logic s, input logic v, input string what);
        for (int i = 0; i < 400 && s !== v; i++)
        begin
            @(posedge clk_sys_in);
            #1;
        end
        if (s !== v)
        begin
            check(what, v, s);
            tally_and_finish();
        end
    endtask : wait_for
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    // The read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : rd
    // One read cycle; l counts clocks from accept to the end of the access.
    task automatic bus_read(input logic [23:0] a, input logic hold_early, output int l);
        @(posedge clk_sys_in);
        req_valid_in <= 1'b1;
        req_in <= '{write: 1'b0, addr: a, wdata: 16'h0000};
        wait_for(req_accept_out, 1'b1, "accept");
        check("address", a, addr_out);
        @(posedge clk_sys_in);
        req_valid_in <= 1'b0;
        if (hold_early)
            hold_n_in <= 1'b0;
        #1 l = 1;
        while (rsp_valid_out !== 1'b1 && l < 400)
        begin
            check("grant during cycle", 0, bus_grant_ack_out);
            @(posedge clk_sys_in);
            #1 l++;
        end
        check("cycle end", 1, rsp_valid_out);
        if (rsp_valid_out !== 1'b1)
            tally_and_finish();
        check("read data", 16'hA5C3, rsp_rdata_out);
    endtask : bus_read
    task automatic s_regs();
        rd(ebr_pkg::ADR_CTRL, rv);
        check("ctrl reset", 32'h0000_0002, rv);
        rd(ebr_pkg::ADR_STAT, rv);
        check("idle state", 9'h001, rv[8:0]);
        rd(4'h3, rv);
        check("unmapped read", 32'h0000_0000, rv);
        wr(ebr_pkg::ADR_TIM0, 32'h0000_0800);
        rd(ebr_pkg::ADR_TIM0, rv);
        check("timing readback", 32'h0000_0800, rv);
    endtask : s_regs
    task automatic s_ready();
        wr(ebr_pkg::ADR_TIM0, 32'h0000_0000);
        bus_read(24'h00_0010, 1'b0, lat);
        check("plain latency", 8, lat);
        wr(ebr_pkg::ADR_TIM0, 32'h0000_0800);
        bus_read(24'h00_0010, 1'b0, base);
        delay = 2;
        bus_read(24'h00_0010, 1'b0, lat);
        check("two ready waits", base + 8, lat);
        delay = 0;
        wr(ebr_pkg::ADR_TIM1, 32'h0000_0820);
        bus_read(24'h80_0000, 1'b0, lat);
        check("window access", 4 * ebr_pkg::TCS_CYC, lat);
        pol_hi = 1'b0;
        wr(ebr_pkg::ADR_CTRL, 32'h0000_0000);
        bus_read(24'h00_0010, 1'b0, lat);
        check("low ready", base, lat);
        pol_hi = 1'b1;
        async_md = 1'b1;
        wr(ebr_pkg::ADR_CTRL, 32'h0000_0003);
        bus_read(24'h00_0010, 1'b0, lat);
        check("async extra wait", 1, lat >= base + 4);
    endtask : s_ready
    task automatic s_arb();
        async_md = 1'b0;
        wr(ebr_pkg::ADR_CTRL, 32'h0000_0006);
        bus_read(24'h00_0010, 1'b1, lat);
        wait_for(bus_grant_ack_out, 1'b1, "grant");
        check("bus floated", 1, bus_oe_n_out);
        @(posedge clk_sys_in);
        req_valid_in <= 1'b1;
        req_in <= '{write: 1'b1, addr: 24'h00_0020, wdata: 16'h5A3C};
        repeat (20)
        begin
            @(posedge clk_sys_in);
            #1 check("stalled", 0, req_accept_out);
        end
        check("regain request", 1, bus_regain_request_out);
        @(posedge clk_sys_in);
        hold_n_in <= 1'b1;
        wait_for(bus_grant_ack_out, 1'b0, "regain");
        check("driven inactive", {1'b0, 5'b11011}, {bus_oe_n_out, ctl_out});
        wait_for(req_accept_out, 1'b1, "stalled request");
        check("write address", 24'h00_0020, addr_out);
        check("write data", 16'h5A3C, data_out);
        wait_for(data_oe_n_out, 1'b0, "write drive");
        check("write strobe", 0, ctl_out.wr_n);
        @(posedge clk_sys_in);
        req_valid_in <= 1'b0;
        hold_n_in <= 1'b0;
        wait_for(bus_grant_ack_out, 1'b1, "second grant");
        check("no regain request", 0, bus_regain_request_out);
        @(posedge clk_sys_in);
        hold_n_in <= 1'b1;
        wait_for(bus_grant_ack_out, 1'b0, "unrequested regain");
    endtask : s_arb
    // Main sequence: reset for eight clocks, then every scenario in turn.
    initial
    begin
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        s_regs();
        s_ready();
        s_arb();
        tally_and_finish();
    end
endmodule : testbench
